// ==== logic/half_bridge_static_gate_sequencer.sv ====
// Three-bridge static gate sequencer with active/free-wheeling detection.
`timescale 1ns/10ps
`default_nettype none
module half_bridge_static_gate_sequencer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic charge_pump_enable,
    input wire logic hold_current_select,
    input wire logic active_fw_detect_enable,
    input wire gate_seq_pkg::bridge_cfg_t cfg [gate_seq_pkg::NUM_BRIDGES],
    input wire logic [gate_seq_pkg::NUM_BRIDGES-1:0] above_upper_threshold,
    input wire logic [gate_seq_pkg::NUM_BRIDGES-1:0] below_lower_threshold,
    input wire logic [gate_seq_pkg::NUM_BRIDGES-1:0] pwm_high_request,
    input wire logic [gate_seq_pkg::NUM_BRIDGES-1:0] pwm_low_request,
    output gate_seq_pkg::bridge_drive_t drive [gate_seq_pkg::NUM_BRIDGES],
    output logic [gate_seq_pkg::NUM_BRIDGES-1:0] high_side_active,
    output logic [gate_seq_pkg::NUM_BRIDGES-1:0] low_side_active,
    output logic [gate_seq_pkg::NUM_BRIDGES-1:0] sequence_busy
);
    import gate_seq_pkg::*;

    //======================================================================
    // Chip-select synchroniser
    //======================================================================
    // Chip select is asynchronous; the first stage feeds only the second.
    logic cs_meta_q, cs_meta_d;
    logic cs_sync_q, cs_sync_d;
    logic cs_last_q, cs_last_d;
    logic cs_rise;

    always_comb begin
        cs_meta_d = chip_select_n;
        cs_sync_d = cs_meta_q;
        cs_last_d = cs_sync_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_last_q <= 1'b1;
        end else begin
            cs_meta_q <= cs_meta_d;
            cs_sync_q <= cs_sync_d;
            cs_last_q <= cs_last_d;
        end
    end

    // Only the synchronised copy is edge-detected.
    assign cs_rise = cs_sync_q & ~cs_last_q;

    //======================================================================
    // Per-bridge sequencers
    //======================================================================
    // Hold step is shared by all bridges.
    logic [STEP_W-1:0] hold_step;
    assign hold_step = hold_current_select ? HOLD_STEP_HIGH
        : HOLD_STEP_LOW;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BRIDGES; gi++) begin : g_bridge
            seq_state_t state_q, state_d;
            logic [1:0] mode_q, mode_d;
            logic [1:0] prev_mode_q, prev_mode_d;
            logic [TIME_W+4:0] cnt_q, cnt_d;
            logic high_act_q, high_act_d;
            logic low_act_q, low_act_d;
            bridge_drive_t drv_q, drv_d;
            logic static_ok;
            logic [STEP_W-1:0] st_step;
            logic [TIME_W+4:0] cross_cyc;
            logic [TIME_W+4:0] charge_cyc;
            logic on_high;

            // Static code n selects step 4n, sixteen monotonic steps.
            assign st_step = {cfg[gi].current_code, 2'b00};
            // Configured times converted to clock cycles, minimum one.
            assign cross_cyc = (cfg[gi].cross_time == '0) ? 13'h0001
                : 13'(cfg[gi].cross_time * CYC_PER_UNIT);
            assign charge_cyc = 13'((cfg[gi].blank_time + FILTER_UNITS)
                * CYC_PER_UNIT);
            assign static_ok = charge_pump_enable
                & ~cfg[gi].pwm_enable;
            assign on_high = (mode_q == MODE_HIGH_ON);

            // Sequencer next state: with static_ok, modes are latched on chip-select rise; otherwise they follow cfg.
            always_comb begin
                state_d = state_q;
                mode_d = mode_q;
                prev_mode_d = prev_mode_q;
                cnt_d = cnt_q;
                if (!static_ok) begin
                    state_d = ST_IDLE;
                    mode_d = cfg[gi].mode;
                    prev_mode_d = cfg[gi].mode;
                end else if (cs_rise && cfg[gi].mode != mode_q) begin
                    prev_mode_d = mode_q;
                    mode_d = cfg[gi].mode;
                    if (cfg[gi].mode == MODE_HIGH_ON
                        || cfg[gi].mode == MODE_LOW_ON) begin
                        // Opposite FET was on: protect cross-current first.
                        if (mode_q == MODE_HIGH_ON || mode_q == MODE_LOW_ON) begin
                            state_d = ST_CROSS;
                            cnt_d = cross_cyc;
                        end else begin
                            state_d = ST_CHARGE;
                            cnt_d = charge_cyc;
                        end
                    end else begin
                        state_d = ST_OFF_DISCH;
                        cnt_d = cross_cyc;
                    end
                end else begin
                    case (state_q)
                        ST_IDLE: begin
                            state_d = ST_HOLD;
                        end
                        ST_CROSS: begin
                            if (cnt_q <= 13'h0001) begin
                                state_d = ST_CHARGE;
                                cnt_d = charge_cyc;
                            end else begin
                                cnt_d = cnt_q - 13'h0001;
                            end
                        end
                        ST_CHARGE, ST_OFF_DISCH: begin
                            if (cnt_q <= 13'h0001) begin
                                state_d = ST_HOLD;
                            end else begin
                                cnt_d = cnt_q - 13'h0001;
                            end
                        end
                        default: begin
                            state_d = state_q;
                        end
                    endcase
                end
            end

            // Drive selection per phase.
            always_comb begin
                drv_d.high.dir = DRV_PASSIVE;
                drv_d.high.step = '0;
                drv_d.low.dir = DRV_PASSIVE;
                drv_d.low.step = '0;
                if (!charge_pump_enable) begin
                    // Passive discharge regardless of mode.
                    drv_d.high.dir = DRV_PASSIVE;
                end else if (static_ok) begin
                    case (state_d)
                        ST_CROSS, ST_OFF_DISCH: begin
                            drv_d.high.dir = DRV_SINK;
                            drv_d.high.step = st_step;
                            drv_d.low.dir = DRV_SINK;
                            drv_d.low.step = st_step;
                        end
                        ST_CHARGE: begin
                            // Opposite FET pinned hard off while charging.
                            if (mode_d == MODE_HIGH_ON) begin
                                drv_d.high.dir = DRV_SOURCE;
                                drv_d.high.step = st_step;
                                drv_d.low.dir = DRV_SINK;
                                drv_d.low.step = HARD_OFF_STEP;
                            end else begin
                                drv_d.low.dir = DRV_SOURCE;
                                drv_d.low.step = st_step;
                                drv_d.high.dir = DRV_SINK;
                                drv_d.high.step = HARD_OFF_STEP;
                            end
                        end
                        default: begin
                            if (mode_d == MODE_PASSIVE) begin
                                drv_d.high.dir = DRV_PASSIVE;
                            end else begin
                                drv_d.high.dir = (mode_d == MODE_HIGH_ON)
                                    ? DRV_SOURCE : DRV_SINK;
                                drv_d.low.dir = (mode_d == MODE_LOW_ON)
                                    ? DRV_SOURCE : DRV_SINK;
                                drv_d.high.step = hold_step;
                                drv_d.low.step = hold_step;
                            end
                        end
                    endcase
                end
            end

            // Active FET decision, taken just before a PWM activation.
            always_comb begin
                high_act_d = high_act_q;
                low_act_d = low_act_q;
                if (pwm_high_request[gi] || pwm_low_request[gi]) begin
                    if (!active_fw_detect_enable) begin
                        high_act_d = pwm_high_request[gi];
                        low_act_d = pwm_low_request[gi];
                    end else if (above_upper_threshold[gi]) begin
                        high_act_d = 1'b0;
                        low_act_d = 1'b1;
                    end else if (below_lower_threshold[gi]) begin
                        high_act_d = 1'b1;
                        low_act_d = 1'b0;
                    end else begin
                        high_act_d = pwm_high_request[gi];
                        low_act_d = ~pwm_high_request[gi];
                    end
                end
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    state_q <= ST_IDLE;
                    mode_q <= MODE_PASSIVE;
                    prev_mode_q <= MODE_PASSIVE;
                    cnt_q <= '0;
                    high_act_q <= 1'b0;
                    low_act_q <= 1'b0;
                    drv_q <= '0;
                end else begin
                    state_q <= state_d;
                    mode_q <= mode_d;
                    prev_mode_q <= prev_mode_d;
                    cnt_q <= cnt_d;
                    high_act_q <= high_act_d;
                    low_act_q <= low_act_d;
                    drv_q <= drv_d;
                end
            end

            assign drive[gi] = drv_q;
            assign high_side_active[gi] = high_act_q;
            assign low_side_active[gi] = low_act_q;
            assign sequence_busy[gi] = (state_q == ST_CROSS)
                || (state_q == ST_CHARGE) || (state_q == ST_OFF_DISCH);

            //==============================================================
            // Checks
            //==============================================================
            sequence s_cross_phase;
                state_q == ST_CROSS && drv_q.high.dir == DRV_SINK
                    && drv_q.low.dir == DRV_SINK;
            endsequence

            AST_PASSIVE_WHEN_PUMP_OFF: assert property (
                @(posedge ref_clk) disable iff (rst)
                !charge_pump_enable |=> drv_q.high.dir == DRV_PASSIVE
                    && drv_q.low.dir == DRV_PASSIVE)
                else $error("Drive not passive with pump off.");

            AST_CROSS_THEN_CHARGE: assert property (
                @(posedge ref_clk) disable iff (rst)
                s_cross_phase ##0 (cnt_q <= 13'h0001 && static_ok
                    && !cs_rise) |=> state_q == ST_CHARGE)
                else $error("Cross phase not followed by charge.");

            AST_HARD_OFF_IN_CHARGE: assert property (
                @(posedge ref_clk) disable iff (rst)
                state_q == ST_CHARGE |-> ((mode_q == MODE_HIGH_ON)
                    ? (drv_q.low.dir == DRV_SINK
                    && drv_q.low.step == HARD_OFF_STEP)
                    : (drv_q.high.dir == DRV_SINK
                    && drv_q.high.step == HARD_OFF_STEP)))
                else $error("No hard-off sink during charge.");

            AST_HOLD_STEP: assert property (
                @(posedge ref_clk) disable iff (rst)
                state_q == ST_HOLD && $stable(state_q) && static_ok
                    && mode_q == MODE_HOLD_OFF && $stable(hold_step)
                    |-> drv_q.high.step == hold_step)
                else $error("Hold step wrong.");

            AST_DETECT_UPPER: assert property (
                @(posedge ref_clk) disable iff (rst)
                active_fw_detect_enable && above_upper_threshold[gi]
                    && (pwm_high_request[gi] || pwm_low_request[gi])
                    |=> low_act_q && !high_act_q)
                else $error("Upper threshold decision wrong.");

            AST_DETECT_LOWER: assert property (
                @(posedge ref_clk) disable iff (rst)
                active_fw_detect_enable && !above_upper_threshold[gi]
                    && below_lower_threshold[gi]
                    && (pwm_high_request[gi] || pwm_low_request[gi])
                    |=> high_act_q && !low_act_q)
                else $error("Lower threshold decision wrong.");

            AST_NO_DETECT: assert property (
                @(posedge ref_clk) disable iff (rst)
                !active_fw_detect_enable && pwm_high_request[gi]
                    |=> high_act_q == 1'b1)
                else $error("PWM FET not active.");

            AST_SKIP_CROSS: assert property (
                @(posedge ref_clk) disable iff (rst)
                static_ok && cs_rise && mode_q == MODE_HOLD_OFF
                    && cfg[gi].mode == MODE_HIGH_ON
                    |=> state_q == ST_CHARGE)
                else $error("Cross phase not skipped.");
        end
    endgenerate

endmodule
`default_nettype wire

// ==== include/gate_seq_pkg.sv ====
// Package with constants and carrier types for the half-bridge gate sequencer.
//==========================================================================
// Overview of operation
// - Static sequencing applies only with bridge PWM off and charge pump on.
// - Mode 01 turns low side on statically, mode 10 turns high side on.
// - A 4-bit static current code selects sixteen monotonic current steps.
// - Hard-off sink keeps one FET off while its opposite turns on.
// - Hold select 0 holds with step 15, select 1 with step 20.
// - Mode 01 to 10 first discharges both gates for the cross-current time.
// - Then charge high, hard-off low for blank plus filter, then hold.
// - Mode 11 to 10 skips cross-current phase and charges at once.
// - Low-side activation mirrors high-side activation with roles swapped.
// - Both-off command discharges both for cross-current time, then holds off.
// - Cross-current and blank times are configured per half-bridge.
// - With detection enabled, decide active and free-wheeling FET before activation.
// - Switch node above upper threshold: high free-wheeling, low active.
// - Switch node below lower threshold: low free-wheeling, high active.
// - Switch node between thresholds: next FET turned on is active.
// - Detection disabled: the PWM-driven FET is the active one.
// - Charge pump off keeps all FETs off by passive discharge.
// - Mode 11 holds both off with hold current; mode 00 passive off.
//==========================================================================
package gate_seq_pkg;

    localparam int NUM_BRIDGES = 3;
    localparam int CODE_W = 4;
    localparam int TIME_W = 8;
    localparam int STEP_W = 6;

    // Phase time unit: each count of a time field is this many nanoseconds.
    localparam int TIME_UNIT_NS = 100;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CYC_PER_UNIT = (TIME_UNIT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Filter time on the drain-source monitor, in time units.
    localparam int FILTER_UNITS = 5;

    // Current steps: static code n maps to step 4*n; hold steps and hard-off.
    localparam logic [STEP_W-1:0] HOLD_STEP_LOW = 6'h0F;
    localparam logic [STEP_W-1:0] HOLD_STEP_HIGH = 6'h14;
    localparam logic [STEP_W-1:0] HARD_OFF_STEP = 6'h3F;

    localparam logic [1:0] MODE_PASSIVE = 2'h0;
    localparam logic [1:0] MODE_LOW_ON = 2'h1;
    localparam logic [1:0] MODE_HIGH_ON = 2'h2;
    localparam logic [1:0] MODE_HOLD_OFF = 2'h3;

    // Gate drive action per FET.
    typedef enum logic [1:0] {
        DRV_PASSIVE = 2'b00,
        DRV_SOURCE = 2'b01,
        DRV_SINK = 2'b10
    } drive_dir_t;

    typedef struct packed {
        drive_dir_t dir;
        logic [STEP_W-1:0] step;
    } gate_drive_t;

    typedef struct packed {
        gate_drive_t high;
        gate_drive_t low;
    } bridge_drive_t;

    typedef struct packed {
        logic [1:0] mode;
        logic pwm_enable;
        logic [CODE_W-1:0] current_code;
        logic [TIME_W-1:0] cross_time;
        logic [TIME_W-1:0] blank_time;
    } bridge_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CROSS = 3'b001,
        ST_CHARGE = 3'b010,
        ST_OFF_DISCH = 3'b011,
        ST_HOLD = 3'b100
    } seq_state_t;

endpackage

// ==== sim/fet_bridge_model.sv ====
// Behavioural model of the three external MOSFET half-bridges.
`timescale 1ns/10ps
`default_nettype none
module fet_bridge_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire gate_seq_pkg::bridge_drive_t drive [gate_seq_pkg::NUM_BRIDGES],
    input wire logic [1:0] node_bias [gate_seq_pkg::NUM_BRIDGES],
    output logic [gate_seq_pkg::NUM_BRIDGES-1:0] above_upper_threshold,
    output logic [gate_seq_pkg::NUM_BRIDGES-1:0] below_lower_threshold
);
    import gate_seq_pkg::*;
    //======================================================================
    // Switch node comparators
    // A sourced gate pulls the node to its rail. With both gates off the
    // load current decides: bias 1 high, bias 2 low, bias 0 leaves the node
    // between the thresholds. Outputs are registered like synced levels.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            above_upper_threshold <= '0;
            below_lower_threshold <= '0;
        end else begin
            for (int i = 0; i < NUM_BRIDGES; i++) begin
                if (drive[i].high.dir == DRV_SOURCE) begin
                    above_upper_threshold[i] <= 1'b1;
                    below_lower_threshold[i] <= 1'b0;
                end else if (drive[i].low.dir == DRV_SOURCE) begin
                    above_upper_threshold[i] <= 1'b0;
                    below_lower_threshold[i] <= 1'b1;
                end else begin
                    above_upper_threshold[i] <= (node_bias[i] == 2'h1);
                    below_lower_threshold[i] <= (node_bias[i] == 2'h2);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/half_bridge_static_gate_sequencer_test.sv ====
// Self-checking testbench of the half-bridge static gate sequencer.
`timescale 1ns/10ps
`default_nettype none
module half_bridge_static_gate_sequencer_test;
    import gate_seq_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic chip_select_n = 1'b1;
    logic charge_pump_enable = 1'b1;
    logic hold_current_select = 1'b0;
    logic active_fw_detect_enable = 1'b0;
    bridge_cfg_t cfg [NUM_BRIDGES];
    bridge_drive_t drive [NUM_BRIDGES];
    logic [1:0] node_bias [NUM_BRIDGES];
    logic [1:0] cur_mode [NUM_BRIDGES];
    logic [NUM_BRIDGES-1:0] above, below, high_side_active, low_side_active;
    logic [NUM_BRIDGES-1:0] pwm_high_request = '0;
    logic [NUM_BRIDGES-1:0] pwm_low_request = '0;
    logic [NUM_BRIDGES-1:0] sequence_busy;
    logic [31:0] seed = 32'h00001ADC;
    int failures = 0;
    int checked = 0;

    half_bridge_static_gate_sequencer half_bridge_static_gate_sequencer_inst (
        .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
        .charge_pump_enable(charge_pump_enable),
        .hold_current_select(hold_current_select),
        .active_fw_detect_enable(active_fw_detect_enable), .cfg(cfg),
        .above_upper_threshold(above), .below_lower_threshold(below),
        .pwm_high_request(pwm_high_request),
        .pwm_low_request(pwm_low_request), .drive(drive),
        .high_side_active(high_side_active),
        .low_side_active(low_side_active), .sequence_busy(sequence_busy));
    fet_bridge_model fet_bridge_model_inst (
        .ref_clk(ref_clk), .rst(rst), .drive(drive), .node_bias(node_bias),
        .above_upper_threshold(above), .below_lower_threshold(below));

    // The 40 MHz clock toggles every half period.
    always #12.5 ref_clk = ~ref_clk;

    //======================================================================
    // Helpers
    // Xorshift keeps the random stream repeatable from its fixed seed.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Phase 0 discharges both, 1 charges with hard-off, 2 holds.
    function automatic bridge_drive_t exp_drive(input int ph,
            input logic [1:0] to, input logic [3:0] code, input logic hsel);
        bridge_drive_t d;
        logic [STEP_W-1:0] st, hs;
        st = {code, 2'b00};
        hs = hsel ? HOLD_STEP_HIGH : HOLD_STEP_LOW;
        d = '0;
        if (ph == 0) begin
            d.high = '{DRV_SINK, st};
            d.low = '{DRV_SINK, st};
        end else if (ph == 1) begin
            d.high = (to == MODE_HIGH_ON) ? '{DRV_SOURCE, st}
                : '{DRV_SINK, HARD_OFF_STEP};
            d.low = (to == MODE_LOW_ON) ? '{DRV_SOURCE, st}
                : '{DRV_SINK, HARD_OFF_STEP};
        end else if (to != MODE_PASSIVE) begin
            d.high = '{(to == MODE_HIGH_ON) ? DRV_SOURCE : DRV_SINK, hs};
            d.low = '{(to == MODE_LOW_ON) ? DRV_SOURCE : DRV_SINK, hs};
        end
        return d;
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Outputs are read on the falling edge, where they are settled.
    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wait_busy(input int b, input logic lvl);
        int n;
        n = 0;
        while (sequence_busy[b] !== lvl) begin
            cycles(1);
            n++;
            if (n > 50) begin
                failures++;
                $display("BAD busy wait expected %b seen %b", lvl,
                    sequence_busy[b]);
                close_out();
            end
        end
    endtask

    task automatic pulse_cs();
        @(posedge ref_clk);
        chip_select_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chip_select_n <= 1'b1;
    endtask

    //======================================================================
    // Mode command with phase checks
    // Phases are sampled mid-way so a one-cycle drive lag cannot mislead.
    task automatic run_cmd(input int b, input logic [1:0] to);
        logic [31:0] r;
        logic [1:0] from;
        logic [3:0] code;
        logic [7:0] ct, bt;
        logic hsel, x_ph, c_ph;
        int cc, ch, n;
        from = cur_mode[b];
        r = rnd();
        code = r[3:0];
        ct = 8'h01 + {6'h00, r[5:4]};
        bt = {6'h00, r[7:6]};
        hsel = r[8];
        @(posedge ref_clk);
        cfg[b].mode <= to;
        cfg[b].current_code <= code;
        cfg[b].cross_time <= ct;
        cfg[b].blank_time <= bt;
        hold_current_select <= hsel;
        pulse_cs();
        cur_mode[b] = to;
        // Any turn-off command discharges first; off to on charges at once.
        c_ph = (to inside {MODE_LOW_ON, MODE_HIGH_ON}) && from != to;
        x_ph = from != to && !(c_ph
            && from inside {MODE_PASSIVE, MODE_HOLD_OFF});
        cc = int'(ct) * CYC_PER_UNIT;
        ch = (int'(bt) + FILTER_UNITS) * CYC_PER_UNIT;
        n = 0;
        if (from == to) begin
            cycles(8);
            check("busy same mode", 32'(sequence_busy[b]), 32'h0);
        end else if (x_ph || c_ph) begin
            wait_busy(b, 1'b1);
            if (x_ph) begin
                cycles(cc / 2);
                check("cross drive", drive[b], exp_drive(0, to, code, hsel));
                cycles(cc - cc / 2);
                n = cc;
            end
            if (c_ph) begin
                cycles(ch / 2);
                check("charge drive", drive[b], exp_drive(1, to, code, hsel));
                cycles(ch - ch / 2);
                n = n + ch;
            end
            cycles(-1 + 1);
            check("busy length", 32'(sequence_busy[b]), 32'h0);
        end else begin
            cycles(8);
        end
        cycles(4);
        check("hold drive", drive[b], exp_drive(2, to, code, hsel));
    endtask

    //======================================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        int b;
        logic [1:0] to;
        for (int i = 0; i < NUM_BRIDGES; i++) begin
            cfg[i] = '{2'h0, 1'b0, 4'h0, 8'h01, 8'h00};
            node_bias[i] = 2'h0;
            cur_mode[i] = MODE_PASSIVE;
        end
        repeat (8) @(posedge ref_clk);
        check("reset drive", drive[1], 32'h0);
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        cycles(4);
        for (int i = 0; i < NUM_BRIDGES; i++) begin
            run_cmd(i, MODE_HOLD_OFF);
        end
        run_cmd(0, MODE_HIGH_ON);
        run_cmd(0, MODE_LOW_ON);
        run_cmd(0, MODE_HIGH_ON);
        run_cmd(0, MODE_HOLD_OFF);
        run_cmd(0, MODE_LOW_ON);
        run_cmd(0, MODE_PASSIVE);
        run_cmd(0, MODE_PASSIVE);
        // Random commands; passive bridges go to hold-off before turn-on.
        repeat (30) begin
            r = rnd();
            b = (r[1:0] == 2'h3) ? 0 : int'(r[1:0]);
            to = r[3:2];
            if (cur_mode[b] == MODE_PASSIVE && to inside {2'h1, 2'h2}) begin
                to = MODE_HOLD_OFF;
            end
            run_cmd(b, to);
        end
        // PWM enabled: a mode change starts no static sequence.
        @(posedge ref_clk);
        cfg[1].pwm_enable <= 1'b1;
        cfg[1].mode <= cur_mode[1] ^ 2'h3;
        pulse_cs();
        cycles(8);
        check("busy in pwm", 32'(sequence_busy[1]), 32'h0);
        // Detection over every enable, node level and requested FET.
        for (int det = 0; det < 2; det++) begin
            for (int bias = 0; bias < 3; bias++) begin
                for (int hi = 0; hi < 2; hi++) begin
                    @(posedge ref_clk);
                    active_fw_detect_enable <= det[0];
                    node_bias[1] <= bias[1:0];
                    repeat (3) @(posedge ref_clk);
                    pwm_high_request[1] <= hi[0];
                    pwm_low_request[1] <= ~hi[0];
                    @(posedge ref_clk);
                    pwm_high_request[1] <= 1'b0;
                    pwm_low_request[1] <= 1'b0;
                    cycles(2);
                    to = (det == 0 || bias == 0) ? {hi[0], ~hi[0]}
                        : (bias == 1) ? 2'h1 : 2'h2;
                    check("active fet", 32'({high_side_active[1],
                        low_side_active[1]}), 32'(to));
                end
            end
        end
        // Pump off: every gate passive whatever the mode.
        @(posedge ref_clk);
        charge_pump_enable <= 1'b0;
        cfg[0].mode <= cur_mode[0] ^ 2'h1;
        pulse_cs();
        cycles(8);
        for (int i = 0; i < NUM_BRIDGES; i++) begin
            check("pump off drive", drive[i], 32'h0);
            check("pump off busy", 32'(sequence_busy[i]), 32'h0);
        end
        close_out();
    end
endmodule
`default_nettype wire
